// ### test_tx_port_statistics_counters.sv
`timescale 1ns/1ns
`include "tsc_defs.svh"

module test_tx_port_statistics_counters;
    logic clk, rst_n, req, irq, ev_valid;
    logic [41:0] cmd;
    logic [15:0] ev_len, ev_wait, maxf, maxp;
    logic [1:0] ev_class, s_axi_bresp, s_axi_rresp;
    logic [4:0] ev_coll;
    logic [2:0] ev_cause, st;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] mdl [34];
    logic [33:0] exp_r [$];
    logic [1:0] exp_b [$];
    int fails, n_compared;
    int edg [6] = '{64, 127, 255, 511, 1023, 1518};
    int lens [16] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1000, 1001, 1023, 1024,
        1518, 1519, 65535};

    tsc_top u_tsc_top (.*);
    tsc_txmodel u_tsc_txmodel (.*);

    // --------
    // Scoreboard
    // --------
    task automatic final_report();
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic guard(inout int n);
        n++;
        if (n > 300) begin
            fails++;
            final_report();
        end
    endtask

    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk(exp_r.pop_front(), {s_axi_rdata, s_axi_rresp});
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, exp_b.pop_front()}, {32'h0, s_axi_bresp});
    end

    // --------
    // Drivers
    // --------
    // Ready raised late at random so the answer must stand
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        exp_b.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            guard(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid && s_axi_bready;
            if (done) s_axi_bready <= 1'b0;
            else if (s_axi_bvalid) s_axi_bready <= 1'($urandom);
        end
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        exp_r.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            guard(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid && s_axi_rready;
            if (done) s_axi_rready <= 1'b0;
            else if (s_axi_rvalid) s_axi_rready <= 1'($urandom);
        end
    endtask

    task automatic send(input logic [15:0] l, input logic [1:0] c, input logic [4:0] k,
            input logic [2:0] q, input logic [15:0] w);
        @(posedge clk);
        req <= 1'b1;
        cmd <= {l, c, k, q, w};
        st[q != 3'h0] = 1'b1;
        if (l > maxf) mdl[6] += 1;
        if (q == 3'h0) begin
            mdl[0] += 32'(l);
            mdl[(c == 2'h3) ? 3 : 1 + c] += 1;
            if (k >= 1 && k <= 15) mdl[6 + k] += 1;
            if (k == 1) mdl[33] += 1;
            if (l > maxf) mdl[32] += 1;
            if (l == 16'd64) mdl[26] += 1;
            for (int b = 0; b < 5; b++)
                if (l > edg[b] && l <= edg[b + 1]) mdl[27 + b] += 1;
        end
        if (q == 3'h1) mdl[4] += 1;
        if (q == 3'h2 && w > 2 * maxp) mdl[5] += 1;
        if (q == 3'h2 && w > maxp) mdl[25] += 1;
        if (q == 3'h3) mdl[22] += 1;
        if (q == 3'h4) mdl[23] += 1;
        if (q == 3'h5) mdl[24] += 1;
    endtask

    // Two edges of counter latency plus the partner's register stage
    task automatic settle();
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic check_all();
        for (int i = 0; i < 34; i++) axi_rd(12'(4 * i), {mdl[i], 2'h0});
        axi_rd(12'h100, {16'h0, maxf, 2'h0});
        axi_rd(12'h104, {16'h0, maxp, 2'h0});
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        maxf = `TSC_MAXFRM_RST;
        maxp = 16'(`TSC_MAXPKT_CYC);
        st = 3'h0;
        foreach (mdl[i]) mdl[i] = 32'h0;
    endtask

    // --------
    // Sequence
    // --------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {rst_n, req, cmd, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        fails = 0;
        n_compared = 0;
        void'($urandom(65));
        do_reset();
        check_all();
        axi_rd(12'h108, 34'h0);
        axi_rd(12'h200, {32'h0, `TSC_RESP_SLVERR});
        axi_rd(12'h0a0, {32'h0, `TSC_RESP_SLVERR});
        axi_wr(12'h300, 32'h1, `TSC_RESP_SLVERR);
        axi_wr(12'h004, 32'h55, `TSC_RESP_OKAY);
        axi_wr(12'h100, 32'h3e8, `TSC_RESP_OKAY);
        axi_wr(12'h104, 32'h10, `TSC_RESP_OKAY);
        axi_wr(12'h10c, 32'h3, `TSC_RESP_OKAY);
        maxf = 16'h03e8;
        maxp = 16'h0010;
        for (int i = 0; i < 16; i++) send(16'(lens[i]), 2'(i), 5'(i), 3'h0, 16'h0);
        for (int i = 1; i < 7; i++) send(16'd1001, 2'h0, 5'h10, 3'(i), 16'h21);
        for (int w = 16; w < 34; w++) send(16'd1001, 2'h1, 5'h0, 3'h2, 16'(w));
        for (int i = 0; i < 60; i++)
            send(16'($urandom_range(1600, 40)), 2'($urandom), 5'($urandom_range(16, 0)),
                3'($urandom_range(6, 0)), 16'($urandom_range(40, 0)));
        settle();
        check_all();
        chk(34'h1, 34'(irq));
        axi_rd(12'h108, {29'h0, st, 2'h0});
        axi_wr(12'h110, 32'h7, `TSC_RESP_OKAY);
        st = 3'h0;
        axi_rd(12'h108, 34'h0);
        chk(34'h0, 34'(irq));
        axi_wr(12'h10c, 32'h1, `TSC_RESP_OKAY);
        send(16'd64, 2'h1, 5'h0, 3'h6, 16'h0);
        settle();
        chk(34'h0, 34'(irq));
        send(16'd64, 2'h2, 5'h1, 3'h0, 16'h0);
        settle();
        chk(34'h1, 34'(irq));
        axi_rd(12'h108, {29'h0, st, 2'h0});
        do_reset();
        check_all();
        final_report();
    end
endmodule

// ### tsc_assertions.sv
`timescale 1ns/1ns

// --------
// Port-level checks
// --------
module tsc_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic wr_take;
    logic rd_take;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Both write channels taken at one edge, as the bench offers them
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    rst_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n |=> !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("busy after reset");
    b_lat_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("late bvalid");
    r_lat_a: assert property (rd_take |=> !s_axi_arready ##1 s_axi_rvalid)
        else $error("late rvalid");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp})) else $error("r dropped");
    r_bad_a: assert property (rd_take && s_axi_araddr >= 12'h114 |->
        ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad read ok");
    b_bad_a: assert property (wr_take && s_axi_awaddr >= 12'h114 |->
        ##2 s_axi_bresp == 2'h2) else $error("bad write ok");
    r_ok_a: assert property (rd_take && s_axi_araddr < 12'h088 |->
        ##2 s_axi_rresp == 2'h0) else $error("counter read refused");
    r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(rd_take, 2))
        else $error("unasked rvalid");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("b not closed");
endmodule

bind tsc_top tsc_checker u_tsc_checker (.*);

// ### tsc_axil.sv
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_axil (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    tsc_pkg::tsc_axi_st_t q;
    tsc_pkg::tsc_axi_st_t d;

    assign wr_en = q.aw_have & q.w_have & ~q.bvalid;
    assign wr_addr = q.aw_addr;
    assign wr_data = q.w_data;
    assign wr_strb = q.w_strb;
    assign rd_en = q.ar_have & ~q.rvalid;
    assign rd_addr = q.ar_addr;

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    always_comb begin
        d = q;
        // Address and data may arrive in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (wr_en) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_err ? `TSC_RESP_SLVERR : `TSC_RESP_OKAY;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.ar_have = 1'b1;
            d.ar_addr = s_axi_araddr;
        end
        if (rd_en) begin
            d.ar_have = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = rd_data;
            d.rresp = rd_err ? `TSC_RESP_SLVERR : `TSC_RESP_OKAY;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        // Ready held low until the answer is taken: one access of each kind
        d.awready = ~d.aw_have & ~d.bvalid;
        d.wready = ~d.w_have & ~d.bvalid;
        d.arready = ~d.ar_have & ~d.rvalid;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// ### tsc_classify.sv
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_classify (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ev_valid,
    input wire logic [15:0] ev_len,
    input wire logic [1:0] ev_class,
    input wire logic [4:0] ev_coll,
    input wire logic [2:0] ev_cause,
    input wire logic [15:0] ev_wait,
    input wire logic [15:0] max_frame,
    input wire logic [15:0] max_pkt,
    output logic [`TSC_NUM_CNT-1:0] inc,
    output logic [15:0] add_len,
    output logic sent,
    output logic dropped
);

    tsc_pkg::tsc_cls_st_t q;
    tsc_pkg::tsc_cls_st_t d;

    function automatic logic in_range(input logic [15:0] len, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (len >= lo) && (len <= hi);
    endfunction

    assign inc = q.inc;
    assign add_len = q.add_len;
    assign sent = q.sent;
    assign dropped = q.dropped;

    always_comb begin
        d = '0;
        if (ev_valid) begin
            d.sent = (ev_cause == tsc_pkg::TSC_SENT);
            d.dropped = ~d.sent;
            d.inc[`TSC_IDX_MTU] = (ev_len > max_frame);
            if (d.sent) begin
                d.add_len = ev_len;
                if (ev_class == tsc_pkg::TSC_UCAST) begin
                    d.inc[`TSC_IDX_UCAST] = 1'b1;
                end else if (ev_class == tsc_pkg::TSC_MCAST) begin
                    d.inc[`TSC_IDX_MCAST] = 1'b1;
                end else begin
                    d.inc[`TSC_IDX_BCAST] = 1'b1;
                end
                for (int i = 1; i <= 15; i++) begin
                    if (ev_coll == 5'(i)) begin
                        d.inc[`TSC_IDX_COLL1 + i - 1] = 1'b1;
                    end
                end
                d.inc[`TSC_IDX_GOOD1] = (ev_coll == 5'h01);
                d.inc[`TSC_IDX_TOOBIG] = (ev_len > max_frame);
                d.inc[`TSC_IDX_BIN64] = (ev_len == `TSC_LEN_MIN);
                d.inc[`TSC_IDX_BIN64 + 1] = in_range(ev_len, `TSC_LEN_MIN + 16'h0001,
                                                     `TSC_LEN_127);
                d.inc[`TSC_IDX_BIN64 + 2] = in_range(ev_len, `TSC_LEN_127 + 16'h0001,
                                                     `TSC_LEN_255);
                d.inc[`TSC_IDX_BIN64 + 3] = in_range(ev_len, `TSC_LEN_255 + 16'h0001,
                                                     `TSC_LEN_511);
                d.inc[`TSC_IDX_BIN64 + 4] = in_range(ev_len, `TSC_LEN_511 + 16'h0001,
                                                     `TSC_LEN_1023);
                d.inc[`TSC_IDX_BIN64 + 5] = in_range(ev_len, `TSC_LEN_1023 + 16'h0001,
                                                     `TSC_LEN_1518);
            end else begin
                d.inc[`TSC_IDX_AGED] = (ev_cause == tsc_pkg::TSC_AGED);
                if (ev_cause == tsc_pkg::TSC_DEFER) begin
                    // Both limits judged alone; a very long wait counts twice
                    d.inc[`TSC_IDX_DEFER] = ({1'b0, ev_wait} > {max_pkt, 1'b0});
                    d.inc[`TSC_IDX_EXDEFER] = (ev_wait > max_pkt);
                end
                d.inc[`TSC_IDX_EXCOLL] = (ev_cause == tsc_pkg::TSC_EXCOLL);
                d.inc[`TSC_IDX_LATE] = (ev_cause == tsc_pkg::TSC_LATE);
                d.inc[`TSC_IDX_CFI] = (ev_cause == tsc_pkg::TSC_CFI);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// ### tsc_defs.svh
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ----------------------------------------
// Counter bank layout
// ----------------------------------------
`define TSC_NUM_CNT 34
`define TSC_IDX_BYTES 0
`define TSC_IDX_UCAST 1
`define TSC_IDX_MCAST 2
`define TSC_IDX_BCAST 3
`define TSC_IDX_AGED 4
`define TSC_IDX_DEFER 5
`define TSC_IDX_MTU 6
`define TSC_IDX_COLL1 7
`define TSC_IDX_EXCOLL 22
`define TSC_IDX_LATE 23
`define TSC_IDX_CFI 24
`define TSC_IDX_EXDEFER 25
`define TSC_IDX_BIN64 26
`define TSC_IDX_TOOBIG 32
`define TSC_IDX_GOOD1 33

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSC_OFF_MAXFRM 12'h100
`define TSC_OFF_MAXPKT 12'h104
`define TSC_OFF_IRQ_STAT 12'h108
`define TSC_OFF_IRQ_EN 12'h10c
`define TSC_OFF_IRQ_CLR 12'h110

// ----------------------------------------
// Status bits and bus answers
// ----------------------------------------
`define TSC_IRQ_SENT 0
`define TSC_IRQ_DROP 1
`define TSC_IRQ_WRAP 2
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2

// ----------------------------------------
// Reset values, sizes and timing
// ----------------------------------------
`define TSC_MAXFRM_RST 16'h05ee
`define TSC_CLK_NS 8
`define TSC_MAXPKT_NS 12304
`define TSC_MAXPKT_CYC (`TSC_MAXPKT_NS / `TSC_CLK_NS)
`define TSC_LEN_MIN 16'h0040
`define TSC_LEN_127 16'h007f
`define TSC_LEN_255 16'h00ff
`define TSC_LEN_511 16'h01ff
`define TSC_LEN_1023 16'h03ff
`define TSC_LEN_1518 16'h05ee

`endif

// ### tsc_pkg.sv
`include "tsc_defs.svh"

package tsc_pkg;

    typedef enum logic [2:0] {
        TSC_SENT = 3'b000,
        TSC_AGED = 3'b001,
        TSC_DEFER = 3'b010,
        TSC_EXCOLL = 3'b011,
        TSC_LATE = 3'b100,
        TSC_CFI = 3'b101,
        TSC_DROP = 3'b110
    } tsc_cause_t;

    typedef enum logic [1:0] {
        TSC_UCAST = 2'b00,
        TSC_MCAST = 2'b01,
        TSC_BCAST = 2'b10
    } tsc_addr_t;

    typedef struct packed {
        logic [`TSC_NUM_CNT-1:0] inc;
        logic [15:0] add_len;
        logic sent;
        logic dropped;
    } tsc_cls_st_t;

    typedef struct packed {
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic ar_have;
        logic [11:0] ar_addr;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tsc_axi_st_t;

    typedef struct packed {
        logic [`TSC_NUM_CNT-1:0][31:0] cnt;
        logic [15:0] max_frame;
        logic [15:0] max_pkt;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic irq;
    } tsc_top_st_t;

endpackage

// ### tsc_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ev_valid,
    input wire logic [15:0] ev_len,
    input wire logic [1:0] ev_class,
    input wire logic [4:0] ev_coll,
    input wire logic [2:0] ev_cause,
    input wire logic [15:0] ev_wait,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // ----------------------------------------
    // State and internal wiring
    // ----------------------------------------
    tsc_pkg::tsc_top_st_t q;
    tsc_pkg::tsc_top_st_t d;

    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic [`TSC_NUM_CNT-1:0] cls_inc;
    logic [15:0] cls_len;
    logic cls_sent;
    logic cls_dropped;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    function automatic logic is_counter(input logic [11:0] addr);
        is_counter = (addr[11:2] < 10'(`TSC_NUM_CNT));
    endfunction

    function automatic logic is_mapped(input logic [11:0] addr);
        logic [11:0] a;
        a = {addr[11:2], 2'b00};
        is_mapped = is_counter(addr) || (a == `TSC_OFF_MAXFRM) || (a == `TSC_OFF_MAXPKT)
                    || (a == `TSC_OFF_IRQ_STAT) || (a == `TSC_OFF_IRQ_EN)
                    || (a == `TSC_OFF_IRQ_CLR);
    endfunction

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    tsc_axil u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // One strobe per frame outcome, registered once before counting
    tsc_classify u_cls (
        .clk(clk),
        .rst_n(rst_n),
        .ev_valid(ev_valid),
        .ev_len(ev_len),
        .ev_class(ev_class),
        .ev_coll(ev_coll),
        .ev_cause(ev_cause),
        .ev_wait(ev_wait),
        .max_frame(q.max_frame),
        .max_pkt(q.max_pkt),
        .inc(cls_inc),
        .add_len(cls_len),
        .sent(cls_sent),
        .dropped(cls_dropped)
    );

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    // Reads only look at state, so counting never stalls for software
    always_comb begin
        logic [11:0] a;
        a = {rd_addr[11:2], 2'b00};
        rd_data = 32'h0000_0000;
        rd_err = ~is_mapped(rd_addr);
        if (is_counter(rd_addr)) begin
            rd_data = q.cnt[rd_addr[7:2]];
        end else if (a == `TSC_OFF_MAXFRM) begin
            rd_data = {16'h0000, q.max_frame};
        end else if (a == `TSC_OFF_MAXPKT) begin
            rd_data = {16'h0000, q.max_pkt};
        end else if (a == `TSC_OFF_IRQ_STAT) begin
            rd_data = {29'h0000_0000, q.irq_stat};
        end else if (a == `TSC_OFF_IRQ_EN) begin
            rd_data = {29'h0000_0000, q.irq_en};
        end
    end

    assign wr_err = ~is_mapped(wr_addr);

    // ----------------------------------------
    // Counters, configuration and interrupt
    // ----------------------------------------
    always_comb begin
        logic [11:0] a;
        logic [32:0] bsum;
        logic [2:0] ev;
        logic [2:0] clr;
        a = {wr_addr[11:2], 2'b00};
        bsum = 33'h0_0000_0000;
        ev = 3'h0;
        clr = 3'h0;
        d = q;
        for (int i = 1; i < `TSC_NUM_CNT; i++) begin
            if (cls_inc[i]) begin
                d.cnt[i] = q.cnt[i] + 32'h0000_0001;
                if (q.cnt[i] == 32'hffff_ffff) begin
                    ev[`TSC_IRQ_WRAP] = 1'b1;
                end
            end
        end
        if (cls_sent) begin
            bsum = {1'b0, q.cnt[`TSC_IDX_BYTES]} + {17'h0_0000, cls_len};
            d.cnt[`TSC_IDX_BYTES] = bsum[31:0];
            ev[`TSC_IRQ_WRAP] = ev[`TSC_IRQ_WRAP] | bsum[32];
        end
        ev[`TSC_IRQ_SENT] = cls_sent;
        ev[`TSC_IRQ_DROP] = cls_dropped;
        // Counters and status are read-only; writes to them are ignored
        if (wr_en && !wr_err) begin
            if (a == `TSC_OFF_MAXFRM) begin
                d.max_frame = merge16(q.max_frame, wr_data, wr_strb);
            end else if (a == `TSC_OFF_MAXPKT) begin
                d.max_pkt = merge16(q.max_pkt, wr_data, wr_strb);
            end else if (a == `TSC_OFF_IRQ_EN) begin
                if (wr_strb[0]) begin
                    d.irq_en = wr_data[2:0];
                end
            end else if (a == `TSC_OFF_IRQ_CLR) begin
                clr = wr_data[2:0] & {3{wr_strb[0]}};
            end
        end
        // New event wins over a clear in the same cycle
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        d.irq = |(d.irq_stat & d.irq_en);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.max_frame <= `TSC_MAXFRM_RST;
            q.max_pkt <= 16'(`TSC_MAXPKT_CYC);
        end else begin
            q <= d;
        end
    end

    assign irq = q.irq;

endmodule

// ### tsc_txmodel.sv
`timescale 1ns/1ns

// --------
// Transmit side stand-in
// --------
module tsc_txmodel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [41:0] cmd,
    output logic ev_valid,
    output logic [15:0] ev_len,
    output logic [1:0] ev_class,
    output logic [4:0] ev_coll,
    output logic [2:0] ev_cause,
    output logic [15:0] ev_wait
);
    initial begin
        ev_valid = 1'b0;
        {ev_len, ev_class, ev_coll, ev_cause, ev_wait} = 42'h0;
    end

    // Fields toggle off the strobe so a design leaning on stale values fails
    always @(posedge clk) begin
        ev_valid <= rst_n && req;
        if (req)
            {ev_len, ev_class, ev_coll, ev_cause, ev_wait} <= cmd;
        else
            {ev_len, ev_class, ev_coll, ev_cause, ev_wait} <=
                ~{ev_len, ev_class, ev_coll, ev_cause, ev_wait};
    end
endmodule
